/* File: src/rxf_pkg.sv */
// shared constants for the receive framer and decoder
package rxf_pkg;
	localparam int          NUM_CHANNELS = 4;
	localparam int          CHAR_W       = 10;
	localparam int          APB_AW       = 12;
	// three-level selects: low, mid (open), high; 2'h3 acts as high
	localparam logic [1:0]  SEL_LOW      = 2'h0;
	localparam logic [1:0]  SEL_MID      = 2'h1;
	// framing patterns, first received bit leftmost
	localparam logic [7:0]  COMMA_POS    = 8'h3e;
	localparam logic [7:0]  COMMA_NEG    = 8'hc1;
	localparam logic [9:0]  K285_NEG     = 10'h0fa;
	localparam logic [9:0]  K285_POS     = 10'h305;
	// framer timing, in bit periods, except ALT_RUN in patterns
	localparam logic [3:0]  LAST_BIT     = 4'h9;
	localparam logic [3:0]  HALF_CHAR    = 4'h5;
	localparam logic [1:0]  MAX_STRETCH  = 2'h2;
	localparam logic [5:0]  CHAR_SPAN    = 6'h0a;
	localparam logic [5:0]  MB_SPAN      = 6'h32;
	localparam logic [5:0]  SINCE_MAX    = 6'h3f;
	localparam logic [2:0]  ALT_RUN      = 3'h4;
	// status codes
	localparam logic [2:0]  STAT_DATA    = 3'h0;
	localparam logic [2:0]  STAT_SPECIAL = 3'h1;
	localparam logic [2:0]  STAT_FRAMING = 3'h3;
	localparam logic [2:0]  STAT_INVALID = 3'h7;
	// register map
	localparam logic [11:0] CTRL_OFS     = 12'h000;
	localparam logic [11:0] STAT_BASE    = 12'h010;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_012b;
	localparam int          CTL_FEN      = 0;
	localparam int          CTL_FTYPE    = 1;
	localparam int          CTL_FSEL     = 3;
	localparam int          CTL_DMODE    = 5;
	localparam int          CTL_RATE     = 7;
	localparam int          CTL_CKSEL    = 8;
endpackage

/* File: src/rxf_bit_sync.sv */
// three-stage synchroniser with agreement filter for line pins
`timescale 1ns/1ps
`default_nettype none
module rxf_bit_sync #(
	parameter int W = 2
) (
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a bit changes only once two settled stages agree
	for (genvar b = 0; b < W; b++) begin : g_bit
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				dout[b] <= 1'b0;
			end else if (s2[b] == s3[b]) begin
				dout[b] <= s3[b];
			end
		end
	end
endmodule
`default_nettype wire

/* File: src/rxf_decoder.sv */
// combinational 10b to 8b character decoder with odd parity
`timescale 1ns/1ps
`default_nettype none
module rxf_decoder (
	input  wire logic [9:0] code,
	input  wire logic [1:0] mode,
	output logic      [9:0] data,
	output logic      [2:0] status,
	output logic            parity
);
	import rxf_pkg::*;

	logic [4:0] d5;
	logic [2:0] d3;
	logic       v6;
	logic       v4;
	logic       k28;
	logic       kalt;
	logic [7:0] kidx;

	always_comb begin
		d5 = 5'h00;
		v6 = 1'b1;
		k28 = 1'b0;
		case (code[9:4])
			6'h27, 6'h18: d5 = 5'h00;
			6'h1d, 6'h22: d5 = 5'h01;
			6'h2d, 6'h12: d5 = 5'h02;
			6'h31:        d5 = 5'h03;
			6'h35, 6'h0a: d5 = 5'h04;
			6'h29:        d5 = 5'h05;
			6'h19:        d5 = 5'h06;
			6'h38, 6'h07: d5 = 5'h07;
			6'h39, 6'h06: d5 = 5'h08;
			6'h25:        d5 = 5'h09;
			6'h15:        d5 = 5'h0a;
			6'h34:        d5 = 5'h0b;
			6'h0d:        d5 = 5'h0c;
			6'h2c:        d5 = 5'h0d;
			6'h1c:        d5 = 5'h0e;
			6'h17, 6'h28: d5 = 5'h0f;
			6'h1b, 6'h24: d5 = 5'h10;
			6'h23:        d5 = 5'h11;
			6'h13:        d5 = 5'h12;
			6'h32:        d5 = 5'h13;
			6'h0b:        d5 = 5'h14;
			6'h2a:        d5 = 5'h15;
			6'h1a:        d5 = 5'h16;
			6'h3a, 6'h05: d5 = 5'h17;
			6'h33, 6'h0c: d5 = 5'h18;
			6'h26:        d5 = 5'h19;
			6'h16:        d5 = 5'h1a;
			6'h36, 6'h09: d5 = 5'h1b;
			6'h0e:        d5 = 5'h1c;
			6'h2e, 6'h11: d5 = 5'h1d;
			6'h1e, 6'h21: d5 = 5'h1e;
			6'h2b, 6'h14: d5 = 5'h1f;
			6'h0f, 6'h30: begin
				d5 = 5'h1c;
				k28 = 1'b1;
			end
			default:      v6 = 1'b0;
		endcase
	end

	always_comb begin
		d3 = 3'h0;
		v4 = 1'b1;
		case (code[3:0])
			4'hb, 4'h4:             d3 = 3'h0;
			4'h9:                   d3 = 3'h1;
			4'h5:                   d3 = 3'h2;
			4'hc, 4'h3:             d3 = 3'h3;
			4'hd, 4'h2:             d3 = 3'h4;
			4'ha:                   d3 = 3'h5;
			4'h6:                   d3 = 3'h6;
			4'he, 4'h1, 4'h7, 4'h8: d3 = 3'h7;
			default:                v4 = 1'b0;
		endcase
		// positive-disparity K28 swaps the balanced sub-blocks
		if (code[9:4] == 6'h30 && (d3 == 3'h1 || d3 == 3'h2 || d3 == 3'h5 || d3 == 3'h6)) begin
			d3 = 3'h7 - d3;
		end
	end

	assign kalt = (code[3:0] == 4'h7 || code[3:0] == 4'h8) &&
		(d5 == 5'h17 || d5 == 5'h1b || d5 == 5'h1d || d5 == 5'h1e);

	always_comb begin
		kidx = {5'h00, d3};
		case (d5)
			5'h17:   kidx = 8'h08;
			5'h1b:   kidx = 8'h09;
			5'h1d:   kidx = 8'h0a;
			5'h1e:   kidx = 8'h0b;
			default: kidx = {5'h00, d3};
		endcase
	end

	always_comb begin
		data = {2'h0, d3, d5};
		status = STAT_DATA;
		if (mode == SEL_LOW) begin
			data = code;
		end else if (!(v6 && v4)) begin
			status = STAT_INVALID;
		end else if (k28 || kalt) begin
			data = (mode == SEL_MID) ? {2'h0, kidx} : {2'h0, d3, d5};
			status = (k28 && d3 == 3'h5) ? STAT_FRAMING : STAT_SPECIAL;
		end
	end

	assign parity = ~^data;
endmodule
`default_nettype wire

/* File: src/rxf_top.sv */
// four-channel receive framer and decoder with apb control
//
// Behaviour
// - Framer searches every bit offset for the framing pattern while enabled.
// - Pattern select: low reserved, mid eight-bit comma, high full K28.5.
// - Detected pattern position sets the boundary for all following characters.
// - Global framer enable low: no bit pattern changes any channel boundary.
// - Global framer enable high: chosen framer type runs on all channels.
// - Low-latency type aligns by stretching the character clock.
// - Low-latency type starts aligning on the first detection.
// - Low-latency stretch adds at most two bit periods per character.
// - Character-rate clock: framed output within nine character clocks.
// - Half-rate clock: framed output within fourteen character clocks.
// - Mid type: realign after two detections within 50 bits, same boundary.
// - High type: realign after four consecutive patterns on one boundary.
// - Decoded data characters report status 000.
// - Decoded special characters report status 001; others use other codes.
// - Decoder mode low passes raw 10-bit characters through.
// - Decoder mode mid maps specials through the vendor column.
// - Decoder mode high maps specials through the alternate column.
// - Odd parity accompanies each output character.
// - Comma compare uses eight bits, not seven.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rxf_top #(
	parameter int NCH = rxf_pkg::NUM_CHANNELS
) (
	input  wire logic                          mclk,
	input  wire logic                          reset,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [rxf_pkg::APB_AW-1:0]    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [NCH-1:0]                rx_serial_data,
	input  wire logic [NCH-1:0]                rx_serial_clock,
	output logic      [NCH*rxf_pkg::CHAR_W-1:0] char_data,
	output logic      [NCH*3-1:0]              channel_status_code,
	output logic      [NCH-1:0]                char_parity,
	output logic      [NCH-1:0]                char_valid,
	output logic      [NCH-1:0]                recovered_clock_output
);
	import rxf_pkg::*;

	logic        framer_global_enable;
	logic [1:0]  framer_type_select;
	logic [1:0]  framing_pattern_select;
	logic [1:0]  decoder_mode_select;
	logic        output_clock_rate_select;
	logic [1:0]  output_clock_source_select;
	logic [31:0] ctrl_word;
	logic [31:0] stat_word [NCH];
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        wr_ctrl;

	// zero-wait slave: data is registered in the setup cycle
	assign pready = 1'b1;
	assign wr_ctrl = psel && penable && pwrite && (paddr == CTRL_OFS);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			framer_global_enable <= CTRL_RESET[CTL_FEN];
			framer_type_select <= CTRL_RESET[CTL_FTYPE +: 2];
			framing_pattern_select <= CTRL_RESET[CTL_FSEL +: 2];
			decoder_mode_select <= CTRL_RESET[CTL_DMODE +: 2];
			output_clock_rate_select <= CTRL_RESET[CTL_RATE];
			output_clock_source_select <= CTRL_RESET[CTL_CKSEL +: 2];
		end else if (wr_ctrl) begin
			// framer type chosen for all channels
			framer_global_enable <= pwdata[CTL_FEN];
			framer_type_select <= pwdata[CTL_FTYPE +: 2];
			framing_pattern_select <= pwdata[CTL_FSEL +: 2];
			decoder_mode_select <= pwdata[CTL_DMODE +: 2];
			output_clock_rate_select <= pwdata[CTL_RATE];
			output_clock_source_select <= pwdata[CTL_CKSEL +: 2];
		end
	end

	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[CTL_FEN] = framer_global_enable;
		ctrl_word[CTL_FTYPE +: 2] = framer_type_select;
		ctrl_word[CTL_FSEL +: 2] = framing_pattern_select;
		ctrl_word[CTL_DMODE +: 2] = decoder_mode_select;
		ctrl_word[CTL_RATE] = output_clock_rate_select;
		ctrl_word[CTL_CKSEL +: 2] = output_clock_source_select;
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = (paddr == CTRL_OFS);
		if (paddr == CTRL_OFS) begin
			rd_word = ctrl_word;
		end
		for (int c = 0; c < NCH; c++) begin
			if (paddr == STAT_BASE + APB_AW'(c * 4)) begin
				rd_word = stat_word[c];
				rd_hit = 1'b1;
			end
		end
	end

	// status words are read-only; writes to them or unmapped addresses error
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_word;
			pslverr <= !rd_hit || (pwrite && paddr != CTRL_OFS);
		end
	end

	for (genvar g = 0; g < NCH; g++) begin : g_ch
		logic [1:0] line_q;
		logic       line_clk_q;
		logic       bit_tick;
		logic       fresh;
		logic [9:0] shifter;
		logic [3:0] bit_pos;
		logic [3:0] stretch_left;
		logic [1:0] stretch_used;
		logic [5:0] since_det;
		logic [2:0] run_len;
		logic       match;
		logic       det;
		logic       ll_mode;
		logic       on_boundary;
		logic       repeat_ok;
		logic       realign;
		logic       hold;
		logic       char_strobe;
		logic [9:0] dec_data;
		logic [2:0] dec_status;
		logic       dec_parity;
		logic [9:0] out_data;
		logic [2:0] out_status;
		logic       out_parity;
		logic       out_valid;
		logic       out_clk;
		logic       aligned;
		logic [7:0] realign_cnt;

		rxf_bit_sync #(
			.W (2)
		) u_sync (
			.mclk  (mclk),
			.reset (reset),
			.din   ({rx_serial_clock[g], rx_serial_data[g]}),
			.dout  (line_q)
		);

		assign bit_tick = line_q[1] && !line_clk_q;

		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				line_clk_q <= 1'b0;
				fresh <= 1'b0;
				shifter <= 10'h000;
			end else begin
				line_clk_q <= line_q[1];
				fresh <= bit_tick;
				if (bit_tick) begin
					shifter <= {shifter[8:0], line_q[0]};
				end
			end
		end

		always_comb begin
			match = 1'b0;
			case (framing_pattern_select)
				SEL_LOW: match = 1'b0;
				SEL_MID: match = (shifter[9:2] == COMMA_POS) || (shifter[9:2] == COMMA_NEG);
				default: match = (shifter == K285_NEG) || (shifter == K285_POS);
			endcase
		end

		assign det = fresh && match && framer_global_enable;
		assign ll_mode = (framer_type_select == SEL_LOW);
		assign on_boundary = (bit_pos == LAST_BIT);

		always_comb begin
			repeat_ok = 1'b0;
			case (framer_type_select)
				SEL_LOW: repeat_ok = 1'b0;
				SEL_MID: repeat_ok = (since_det != 6'h00) && (since_det <= MB_SPAN) &&
					((since_det % CHAR_SPAN) == 6'h00);
				default: repeat_ok = (since_det == CHAR_SPAN) && (run_len >= ALT_RUN - 3'h1);
			endcase
		end

		assign realign = det && repeat_ok;
		// two bit periods per character at most
		assign hold = fresh && (bit_pos == 4'h0) && (stretch_left != 4'h0) &&
			(stretch_used < MAX_STRETCH);

		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				bit_pos <= 4'h0;
				stretch_left <= 4'h0;
				stretch_used <= 2'h0;
			end else if (fresh) begin
				if (realign) begin
					bit_pos <= 4'h0;
					stretch_left <= 4'h0;
					stretch_used <= 2'h0;
				end else if (hold) begin
					stretch_left <= stretch_left - 4'h1;
					stretch_used <= stretch_used + 2'h1;
				end else begin
					bit_pos <= on_boundary ? 4'h0 : bit_pos + 4'h1;
					if (on_boundary) begin
						stretch_used <= 2'h0;
					end
					if (det && ll_mode) begin
						stretch_left <= on_boundary ? 4'h0 : bit_pos + 4'h1;
					end
				end
			end
		end

		// bit distance since the previous detection, zero until one is seen
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				since_det <= 6'h00;
				run_len <= 3'h0;
			end else if (fresh) begin
				if (det) begin
					since_det <= 6'h01;
					if (since_det != CHAR_SPAN) begin
						run_len <= 3'h1;
					end else if (run_len != 3'h7) begin
						run_len <= run_len + 3'h1;
					end
				end else if (since_det != 6'h00 && since_det != SINCE_MAX) begin
					since_det <= since_det + 6'h01;
				end
			end
		end

		rxf_decoder u_dec (
			.code   (shifter),
			.mode   (decoder_mode_select),
			.data   (dec_data),
			.status (dec_status),
			.parity (dec_parity)
		);

		assign char_strobe = fresh && (on_boundary || realign);

		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				out_valid <= 1'b0;
				out_data <= 10'h000;
				out_status <= STAT_DATA;
				out_parity <= 1'b1;
			end else begin
				out_valid <= char_strobe;
				if (char_strobe) begin
					out_data <= dec_data;
					out_status <= dec_status;
					out_parity <= dec_parity;
				end
			end
		end

		// held bit zero widens the high phase, so stretch shows on the clock
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				out_clk <= 1'b0;
			end else if (output_clock_rate_select) begin
				if (char_strobe) begin
					out_clk <= !out_clk;
				end
			end else begin
				out_clk <= (bit_pos < HALF_CHAR);
			end
		end

		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				aligned <= 1'b0;
				realign_cnt <= 8'h00;
			end else if (det) begin
				aligned <= on_boundary || realign;
				if (!on_boundary && (realign || ll_mode)) begin
					realign_cnt <= realign_cnt + 8'h01;
				end
			end
		end

		assign stat_word[g] = {8'h00, realign_cnt, 1'b0, aligned, out_parity, out_status,
			out_data};
		assign char_data[g*CHAR_W +: CHAR_W] = out_data;
		assign channel_status_code[g*3 +: 3] = out_status;
		assign char_parity[g] = out_parity;
		assign char_valid[g] = out_valid;
		assign recovered_clock_output[g] = out_clk;
	end
endmodule
`default_nettype wire

/* File: tb/rxf_top_props.sv */
// assertion checker bound to the receive framer top
`timescale 1ns/1ps
`default_nettype none
module rxf_top_props
	import rxf_pkg::*;
#(
	parameter int NCH = NUM_CHANNELS
) (
	input wire logic                           mclk,
	input wire logic                           reset,
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic                           pwrite,
	input wire logic [rxf_pkg::APB_AW-1:0]     paddr,
	input wire logic [31:0]                    pwdata,
	input wire logic [31:0]                    prdata,
	input wire logic                           pready,
	input wire logic                           pslverr,
	input wire logic [NCH*rxf_pkg::CHAR_W-1:0] char_data,
	input wire logic [NCH*3-1:0]               channel_status_code,
	input wire logic [NCH-1:0]                 char_parity,
	input wire logic [NCH-1:0]                 char_valid
);
	logic [31:0] shadow;
	logic        setup;
	logic        mapped;
	assign setup  = psel && !penable;
	assign mapped = paddr == CTRL_OFS || (paddr[11:4] == STAT_BASE[11:4] && paddr[1:0] == 2'h0);
	// expected control word, tracks completed writes
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			shadow <= CTRL_RESET;
		end else if (psel && penable && pwrite && pready && paddr == CTRL_OFS) begin
			shadow <= {22'h00_0000, pwdata[9:0]};
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	property p_ready;
		pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_err_bad;
		setup && !mapped |=> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_err_bad: assert property (p_err_bad) else $error("unmapped not refused");
	property p_err_ro;
		setup && pwrite && paddr != CTRL_OFS |=> pslverr;
	endproperty
	a_err_ro: assert property (p_err_ro) else $error("status write not refused");
	property p_err_ok;
		setup && paddr == CTRL_OFS |=> !pslverr;
	endproperty
	a_err_ok: assert property (p_err_ok) else $error("control access refused");
	property p_ctrl_rd;
		setup && !pwrite && paddr == CTRL_OFS |=> prdata == shadow;
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
	property p_rd_hold;
		!setup |=> $stable(prdata) && $stable(pslverr);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_parity;
		^{char_data[9:0], char_parity[0]};
	endproperty
	a_parity: assert property (p_parity) else $error("parity not odd");
	property p_hold;
		!char_valid[0] |-> $stable(char_data[9:0]) && $stable(channel_status_code[2:0]);
	endproperty
	a_hold: assert property (p_hold) else $error("char changed without valid");
	property p_pulse;
		char_valid[0] |=> !char_valid[0] [*8];
	endproperty
	a_pulse: assert property (p_pulse) else $error("valid too long or too close");
	c_bad: cover property (setup && !mapped);
	c_spec: cover property (char_valid[0] && channel_status_code[2:0] == STAT_SPECIAL);
	c_frm: cover property (char_valid[0] && channel_status_code[2:0] == STAT_FRAMING);
endmodule
`default_nettype wire

/* File: tb/rxf_link_tx.sv */
// remote serial transmitter model for the receive pins
`timescale 1ns/1ps
`default_nettype none
module rxf_link_tx (
	input  wire logic mclk,
	output logic      ser_data,
	output logic      ser_clock
);
	initial begin
		ser_data  = 1'b0;
		ser_clock = 1'b0;
	end
	task automatic send_bit(input logic b);
		@(posedge mclk);
		ser_data <= b;
		repeat (4) @(posedge mclk);
		ser_clock <= 1'b1;
		repeat (4) @(posedge mclk);
		ser_clock <= 1'b0;
		// released line shows the inverse, never a stale bit
		ser_data <= ~b;
	endtask
	task automatic send_char(input logic [9:0] c);
		for (int i = 9; i >= 0; i--) begin
			send_bit(c[i]);
		end
	endtask
endmodule
`default_nettype wire

/* File: tb/rx_framer_10b8b_decoder_test.sv */
// self-checking bench for the receive framer and decoder
`timescale 1ns/1ps
`default_nettype none
module rx_framer_10b8b_decoder_test;
	import rxf_pkg::*;
	typedef struct packed {
		logic [9:0] ctrl;
		logic [3:0] pad;
		logic [3:0] tail;
		logic [9:0] pre;
		logic [9:0] code;
		logic [9:0] exp;
		logic [2:0] st;
		logic [1:0] chk;
	} rxf_case_t;
	// ctrl, pad bits, tail bits, preamble, code, data, status, check mask
	localparam rxf_case_t ROWS [16] = '{
		'{10'h12b, 4'h0, 4'h0, 10'h0fa, 10'h2aa, 10'h0b5, 3'h0, 2'h3},
		'{10'h12b, 4'h0, 4'h0, 10'h0fa, 10'h0f4, 10'h000, 3'h1, 2'h3},
		'{10'h12b, 4'h0, 4'h0, 10'h0fa, 10'h3a8, 10'h008, 3'h1, 2'h3},
		'{10'h14b, 4'h0, 4'h0, 10'h0fa, 10'h0f4, 10'h01c, 3'h1, 2'h3},
		'{10'h14b, 4'h0, 4'h0, 10'h0fa, 10'h3a8, 10'h0f7, 3'h1, 2'h3},
		'{10'h12b, 4'h0, 4'h0, 10'h0fa, 10'h0fa, 10'h000, 3'h3, 2'h2},
		'{10'h12b, 4'h0, 4'h0, 10'h0fa, 10'h000, 10'h000, 3'h7, 2'h2},
		'{10'h10b, 4'h3, 4'h0, 10'h0fa, 10'h155, 10'h155, 3'h0, 2'h1},
		'{10'h12d, 4'h7, 4'h0, 10'h0fa, 10'h2aa, 10'h0b5, 3'h0, 2'h3},
		'{10'h133, 4'h4, 4'h0, 10'h0fa, 10'h155, 10'h04a, 3'h0, 2'h3},
		'{10'h129, 4'h3, 4'h0, 10'h0fa, 10'h2aa, 10'h0b5, 3'h0, 2'h3},
		'{10'h1a9, 4'h5, 4'h0, 10'h0fa, 10'h155, 10'h04a, 3'h0, 2'h3},
		'{10'h10a, 4'h5, 4'h5, 10'h0fa, 10'h2aa, 10'h15f, 3'h0, 2'h1},
		'{10'h103, 4'h5, 4'h5, 10'h0fa, 10'h2aa, 10'h15f, 3'h0, 2'h1},
		'{10'h10b, 4'h5, 4'h5, 10'h0fc, 10'h2aa, 10'h15f, 3'h0, 2'h1},
		'{10'h10b, 4'h3, 4'h0, 10'h0fa, 10'h2aa, 10'h2aa, 3'h0, 2'h1}
	};
	logic        mclk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tx_data;
	logic        tx_clock;
	logic [39:0] char_data;
	logic [11:0] channel_status_code;
	logic [3:0]  char_parity;
	logic [3:0]  char_valid;
	logic [3:0]  rclk_out;
	logic [9:0]  cap0;
	logic [9:0]  cap3;
	logic [2:0]  st0;
	logic        par0;
	logic [31:0] rd;
	logic        err;
	int          n_mismatch;
	int          tests_run;
	rxf_top i_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_serial_data({4{tx_data}}), .rx_serial_clock({4{tx_clock}}), .char_data(char_data),
		.channel_status_code(channel_status_code), .char_parity(char_parity),
		.char_valid(char_valid), .recovered_clock_output(rclk_out));
	rxf_link_tx i_tx (.mclk(mclk), .ser_data(tx_data), .ser_clock(tx_clock));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (char_valid[0] === 1'b1) begin
			cap0 <= char_data[9:0];
			st0  <= channel_status_code[2:0];
			par0 <= char_parity[0];
		end
		if (char_valid[3] === 1'b1) begin
			cap3 <= char_data[39:30];
		end
	end
	task automatic test_done();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			n_mismatch++;
			$display("ERROR %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			test_done();
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input rxf_case_t c);
		logic [9:0] p;
		apb(1'b1, CTRL_OFS, {22'h00_0000, c.ctrl});
		repeat (c.pad) i_tx.send_bit(1'b1);
		// alternate disparity so both pattern polarities occur
		p = c.pre;
		repeat (9) begin
			i_tx.send_char(p);
			p = ~p;
		end
		i_tx.send_char(c.code);
		repeat (c.tail) i_tx.send_bit(1'b1);
		repeat (12) @(posedge mclk);
		if (c.chk[0]) begin
			check(cap0, c.exp);
			check(cap3, c.exp);
		end
		if (c.chk[1]) begin
			check(st0, c.st);
		end
		check(par0, ~^cap0);
	endtask
	initial begin
		reset   = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
		repeat (20) @(posedge mclk);
		check(char_data[39:20], 32'h0000_0000);
		check(char_data[19:0], 32'h0000_0000);
		check({channel_status_code, char_parity, char_valid}, {12'h000, 4'hf, 4'h0});
		check(prdata, 32'h0000_0000);
		check({pslverr, pready, rclk_out}, {1'b0, 1'b1, 4'h0});
		reset <= 1'b0;
		apb(1'b0, CTRL_OFS, 32'h0);
		check(rd, CTRL_RESET);
		foreach (ROWS[i]) begin
			run(ROWS[i]);
		end
		// refused accesses: unmapped, read-only status, then a mapped read
		apb(1'b0, 12'h020, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0000_0000);
		apb(1'b1, STAT_BASE, 32'hffff_ffff);
		check(err, 1'b1);
		apb(1'b0, STAT_BASE + 12'h00c, 32'h0);
		check(err, 1'b0);
		apb(1'b0, CTRL_OFS, 32'h0);
		check(rd, 32'h0000_010b);
		@(posedge mclk);
		reset <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		apb(1'b0, CTRL_OFS, 32'h0);
		check(rd, CTRL_RESET);
		test_done();
	end
endmodule
bind rxf_top rxf_top_props #(.NCH(NCH)) i_props (.mclk(mclk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .char_data(char_data),
	.channel_status_code(channel_status_code), .char_parity(char_parity),
	.char_valid(char_valid));
`default_nettype wire
